// >>> hdl/crf_capture_record_framer.sv
// file: capture record framer top level
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: timestamp bytes go out least significant first
// RULE_02: other header fields go out most significant first
// RULE_03: payload bytes pass in arrival order
// RULE_04: header sixteen bytes, then record body
// RULE_05: type byte holds record subtype code
// RULE_06: flags low two bits give interface
// RULE_07: flags bit two marks varying lengths
// RULE_08: flags bit three marks truncated record
// RULE_09: flags bit four marks receive error
// RULE_10: flags bit five internal error, top zero
// RULE_11: record length counts all emitted bytes
// RULE_12: loss counter counts drops, saturates high
// RULE_13: wire length reports link length
// RULE_14: ethernet adds offset and pad bytes
// RULE_15: receiver ignores offset byte contents
// RULE_16: hardware timestamp taken at arrival
// RULE_17: timestamp is 64-bit seconds since epoch
// RULE_18: upper word seconds, lower word fraction
// RULE_19: unresolved fraction bits written zero
// RULE_20: one-byte type, flags; 16-bit lengths
// RULE_21: loss counter cleared after being emitted
module crf_capture_record_framer #(
  parameter int MAX_BODY = 2048,
  parameter int RES_BITS = 24,
  parameter logic [31:0] FRAC_STEP = 32'h000001ad,
  parameter logic [7:0] REC_TYPE = crf_pkg::ethernet_record_code
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ts_load,
  input wire logic [63:0] ts_load_value,
  input wire logic varlen_mode,
  input wire logic [15:0] snap_len,
  input wire logic pkt_start,
  input wire crf_pkg::crf_start_t pkt_info,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  output logic pkt_ready,
  input wire logic pkt_drop,
  output crf_pkg::crf_beat_t rec_beat,
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [63:0] ts_now,
  output logic [15:0] loss_count
);
  // ************************************************
  // timestamp clock and packet buffer
  // ************************************************
  crf_ts_clock #(
    .RES_BITS(RES_BITS),
    .FRAC_STEP(FRAC_STEP)
  ) u_ts (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(ts_load),
    .load_value(ts_load_value),
    .ts(ts_now)
  );

  localparam int AW = $clog2(MAX_BODY);
  logic [7:0] body_mem [MAX_BODY];

  typedef enum {ST_IDLE, ST_RECV, ST_HDR, ST_BODY} crf_state_t;
  crf_state_t state_reg, state_next;
  logic [63:0] ts_reg, ts_next;
  logic [7:0] flags_reg, flags_next;
  logic [15:0] wlen_reg, wlen_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] rd_reg, rd_next;
  logic [4:0] hidx_reg, hidx_next;
  logic [15:0] lctr_reg, lctr_next;
  logic [15:0] lsnap_reg, lsnap_next;
  logic [15:0] lim_reg, lim_next;
  logic trunc_reg, trunc_next;
  logic [15:0] rlen;
  logic [15:0] hdr_len;
  logic [7:0] hdr_byte;
  logic is_eth;
  logic mem_wr;
  logic hdr_done;

  // maps a 16-bit field to its big-endian byte
  function automatic logic [7:0] be16(input logic [15:0] v, input logic hi);
    be16 = hi ? v[15:8] : v[7:0];
  endfunction : be16

  assign is_eth = (REC_TYPE == crf_pkg::ethernet_record_code); // see RULE_14
  assign hdr_len = is_eth ? crf_pkg::ETH_LEN16 : crf_pkg::HDR_LEN16;
  assign rlen = hdr_len + cnt_reg; // see RULE_11
  assign pkt_ready = (state_reg == ST_RECV) || (state_reg == ST_IDLE);
  assign mem_wr = (state_reg == ST_RECV) && pkt_valid && (cnt_reg < lim_reg);
  assign loss_count = lctr_reg;

  // ************************************************
  // header byte selection
  // ************************************************
  always_comb begin
    hdr_byte = 8'h00;
    if (hidx_reg < 5'(crf_pkg::TS_BYTES)) begin
      hdr_byte = ts_reg[8 * hidx_reg[2:0] +: 8]; // see RULE_01 RULE_18
    end else if (hidx_reg == 5'h08) begin
      hdr_byte = REC_TYPE; // see RULE_05 RULE_20
    end else if (hidx_reg == 5'h09) begin
      hdr_byte = flags_reg;
    end else if (hidx_reg == 5'h0a) begin
      hdr_byte = be16(rlen, 1'b1); // see RULE_02
    end else if (hidx_reg == 5'h0b) begin
      hdr_byte = be16(rlen, 1'b0);
    end else if (hidx_reg == 5'h0c) begin
      hdr_byte = be16(lsnap_reg, 1'b1); // see RULE_12
    end else if (hidx_reg == 5'h0d) begin
      hdr_byte = be16(lsnap_reg, 1'b0);
    end else if (hidx_reg == 5'h0e) begin
      hdr_byte = be16(wlen_reg, 1'b1); // see RULE_13
    end else if (hidx_reg == 5'h0f) begin
      hdr_byte = be16(wlen_reg, 1'b0);
    end else if (hidx_reg == 5'h10) begin
      hdr_byte = crf_pkg::OFFSET_VAL; // see RULE_15
    end else begin
      hdr_byte = crf_pkg::PAD_VAL;
    end
  end

  assign hdr_done = (hidx_reg == 5'(hdr_len - 16'h0001));

  // ************************************************
  // output beat
  // ************************************************
  always_comb begin
    rec_valid = (state_reg == ST_HDR) || (state_reg == ST_BODY);
    rec_beat.sor = (state_reg == ST_HDR) && (hidx_reg == crf_pkg::IDX_ZERO);
    if (state_reg == ST_HDR) begin
      rec_beat.data = hdr_byte;
      rec_beat.eor = hdr_done && (cnt_reg == crf_pkg::ZERO16);
    end else begin
      rec_beat.data = body_mem[rd_reg[AW-1:0]]; // see RULE_03
      rec_beat.eor = (rd_reg + 16'h0001 == cnt_reg);
    end
  end

  // payload store
  always_ff @(posedge core_clk) begin
    if (mem_wr) begin
      body_mem[cnt_reg[AW-1:0]] <= pkt_data; // see RULE_03
    end
  end

  // ************************************************
  // framer state machine
  // ************************************************
  always_comb begin
    state_next = state_reg;
    ts_next = ts_reg;
    flags_next = flags_reg;
    wlen_next = wlen_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    hidx_next = hidx_reg;
    lsnap_next = lsnap_reg;
    lim_next = lim_reg;
    trunc_next = trunc_reg;
    lctr_next = lctr_reg;
    // loss counter saturates, see RULE_12
    if (pkt_drop && (lctr_reg != crf_pkg::LOSS_MAX)) begin
      lctr_next = lctr_reg + 16'h0001;
    end
    case (state_reg)
      ST_IDLE: begin
        if (pkt_start) begin
          ts_next = ts_now; // see RULE_16 RULE_17 RULE_19
          wlen_next = pkt_info.wire_len; // see RULE_13
          flags_next = 8'h00; // see RULE_10
          flags_next[1:0] = pkt_info.intf; // see RULE_06
          flags_next[crf_pkg::FLG_VARLEN] = varlen_mode; // see RULE_07
          flags_next[crf_pkg::FLG_RXERR] = pkt_info.rx_err; // see RULE_09
          flags_next[crf_pkg::FLG_INTERR] = pkt_info.int_err; // see RULE_10
          cnt_next = crf_pkg::ZERO16;
          trunc_next = 1'b0;
          lim_next = (snap_len < 16'(MAX_BODY)) ? snap_len : 16'(MAX_BODY);
          state_next = ST_RECV;
        end
      end
      ST_RECV: begin
        if (pkt_valid) begin
          if (cnt_reg < lim_reg) begin
            cnt_next = cnt_reg + 16'h0001;
          end else begin
            trunc_next = 1'b1; // see RULE_08
          end
          if (pkt_last) begin
            flags_next[crf_pkg::FLG_TRUNC] = trunc_reg || (cnt_reg >= lim_reg); // see RULE_08
            hidx_next = crf_pkg::IDX_ZERO;
            lsnap_next = lctr_reg; // a drop in this cycle goes to the next record
            lctr_next = crf_pkg::ZERO16; // see RULE_21
            if (pkt_drop) begin
              lctr_next = 16'h0001; // set wins over the clear, counted once only
            end
            state_next = ST_HDR;
          end
        end
      end
      ST_HDR: begin
        if (rec_ready) begin
          hidx_next = hidx_reg + crf_pkg::IDX_ONE; // see RULE_04
          if (hdr_done) begin
            rd_next = crf_pkg::ZERO16;
            state_next = (cnt_reg == crf_pkg::ZERO16) ? ST_IDLE : ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (rec_ready) begin
          rd_next = rd_reg + 16'h0001;
          if (rec_beat.eor) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      ts_reg <= 64'h0000000000000000;
      flags_reg <= 8'h00;
      wlen_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      rd_reg <= 16'h0000;
      hidx_reg <= 5'h00;
      lsnap_reg <= 16'h0000;
      lim_reg <= 16'h0000;
      trunc_reg <= 1'b0;
      lctr_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      ts_reg <= ts_next;
      flags_reg <= flags_next;
      wlen_reg <= wlen_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      hidx_reg <= hidx_next;
      lsnap_reg <= lsnap_next;
      lim_reg <= lim_next;
      trunc_reg <= trunc_next;
      lctr_reg <= lctr_next;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  a_loss_saturates: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_12
    (lctr_reg == crf_pkg::LOSS_MAX && state_reg != ST_RECV) |=> lctr_reg == crf_pkg::LOSS_MAX)
    else $error("loss counter wrapped");
  a_loss_clears: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_21
    (state_reg == ST_RECV && state_next == ST_HDR) |=> lctr_reg <= 16'h0001)
    else $error("loss counter not cleared");
  a_flags_reserved: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_10
    flags_reg[7:6] == 2'b00)
    else $error("reserved flag set");
  a_type_byte: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_05
    (state_reg == ST_HDR && hidx_reg == 5'h08) |-> rec_beat.data == REC_TYPE)
    else $error("wrong type byte");
  a_ts_low_first: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_01
    (state_reg == ST_HDR && hidx_reg == 5'h00) |-> rec_beat.data == ts_reg[7:0])
    else $error("timestamp not low byte first");
  a_rlen_msb: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_02
    (state_reg == ST_HDR && hidx_reg == 5'h0a) |-> rec_beat.data == rlen[15:8])
    else $error("record length not big endian");
  a_ts_capture: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_16
    (state_reg == ST_IDLE && pkt_start) |=> ts_reg == $past(ts_now))
    else $error("timestamp not taken at arrival");
  a_ts_res_zero: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_19
    (state_reg == ST_IDLE && pkt_start) |=> ts_reg[31 - RES_BITS:0] == '0)
    else $error("unresolved fraction bits set");
  a_intf_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_06
    (state_reg == ST_IDLE && pkt_start) |=> flags_reg[1:0] == $past(pkt_info.intf))
    else $error("interface flags wrong");
  a_start_mark: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_04
    (state_reg == ST_RECV && pkt_valid && pkt_last) |=> rec_valid && rec_beat.sor)
    else $error("record did not start after last byte");
  a_refused_start: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_16
    (state_reg != ST_IDLE && pkt_start) |=> ts_reg == $past(ts_reg))
    else $error("busy start retook timestamp");
  a_beat_stands: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_03
    (rec_valid && !rec_ready) |=> rec_valid && $stable(rec_beat))
    else $error("beat changed while stalled");
  a_trunc_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_08
    (state_reg == ST_RECV && pkt_valid && pkt_last && cnt_reg >= lim_reg) |=> flags_reg[crf_pkg::FLG_TRUNC])
    else $error("truncation not flagged");
  a_no_trunc: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_08
    (state_reg == ST_RECV && pkt_valid && pkt_last && !trunc_reg && cnt_reg < lim_reg) |=>
    !flags_reg[crf_pkg::FLG_TRUNC])
    else $error("false truncation flag");
  a_body_cap: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_08
    cnt_reg <= lim_reg)
    else $error("body exceeds limit");
  a_record_ends: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_11
    (rec_valid && rec_ready && rec_beat.eor) |=> !rec_valid)
    else $error("bytes after end of record");
  a_ts_seconds: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_18
    (state_reg == ST_HDR && hidx_reg == 5'h04) |-> rec_beat.data == ts_reg[39:32])
    else $error("seconds not in upper word");
  a_varlen_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_07
    (state_reg == ST_IDLE && pkt_start) |=> flags_reg[crf_pkg::FLG_VARLEN] == $past(varlen_mode))
    else $error("varying length flag wrong");
  a_rxerr_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_09
    (state_reg == ST_IDLE && pkt_start) |=> flags_reg[crf_pkg::FLG_RXERR] == $past(pkt_info.rx_err))
    else $error("receive error flag wrong");
  a_interr_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_10
    (state_reg == ST_IDLE && pkt_start) |=> flags_reg[crf_pkg::FLG_INTERR] == $past(pkt_info.int_err))
    else $error("internal error flag wrong");
  a_wlen_capture: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_13
    (state_reg == ST_IDLE && pkt_start) |=> wlen_reg == $past(pkt_info.wire_len))
    else $error("wire length not taken");
  a_loss_counts: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_12
    (pkt_drop && lctr_reg < crf_pkg::LOSS_MAX && !(state_reg == ST_RECV && pkt_valid && pkt_last)) |=>
    lctr_reg == $past(lctr_reg) + 16'h0001)
    else $error("drop not counted");
  a_loss_snapshot: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_12
    (state_reg == ST_RECV && pkt_valid && pkt_last) |=> lsnap_reg == $past(lctr_reg))
    else $error("loss snapshot wrong");
  a_loss_hi_first: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_02
    (state_reg == ST_HDR && hidx_reg == 5'h0c) |-> rec_beat.data == lsnap_reg[15:8])
    else $error("loss count not big endian");
  a_pad_zero: assert property (@(posedge core_clk) disable iff (!nrst) // see RULE_14
    (is_eth && state_reg == ST_HDR && hidx_reg == 5'h11) |-> rec_beat.data == crf_pkg::PAD_VAL)
    else $error("pad byte wrong");
endmodule : crf_capture_record_framer
`default_nettype wire

// >>> hdl/crf_pkg.sv
// package: capture record framer constants and carrier types
package crf_pkg;
  localparam int HDR_BYTES = 16;
  localparam int ETH_EXTRA = 2;
  localparam int TS_BYTES = 8;
  localparam logic [7:0] legacy_record_code = 8'h00;
  localparam logic [7:0] hdlc_pos_record_code = 8'h01;
  localparam logic [7:0] ethernet_record_code = 8'h02;
  localparam logic [7:0] atm_cell_record_code = 8'h03;
  localparam logic [7:0] aal5_frame_record_code = 8'h04;
  localparam logic [7:0] multichannel_hdlc_record_code = 8'h05;
  localparam logic [7:0] multichannel_raw_record_code = 8'h06;
  localparam logic [7:0] multichannel_atm_record_code = 8'h07;
  localparam int FLG_VARLEN = 2;
  localparam int FLG_TRUNC = 3;
  localparam int FLG_RXERR = 4;
  localparam int FLG_INTERR = 5;
  localparam logic [15:0] LOSS_MAX = 16'hffff;
  localparam logic [15:0] HDR_LEN16 = 16'h0010;
  localparam logic [15:0] ETH_LEN16 = 16'h0012;
  localparam logic [7:0] OFFSET_VAL = 8'h00;
  localparam logic [7:0] PAD_VAL = 8'h00;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [4:0] IDX_ZERO = 5'h00;
  localparam logic [4:0] IDX_ONE = 5'h01;
  localparam int CLK_HZ = 10000000;
  // packet start descriptor
  typedef struct packed {
    logic [1:0] intf;
    logic rx_err;
    logic int_err;
    logic [15:0] wire_len;
  } crf_start_t;
  // output byte stream beat
  typedef struct packed {
    logic [7:0] data;
    logic sor;
    logic eor;
  } crf_beat_t;
endpackage : crf_pkg

// >>> hdl/crf_ts_clock.sv
// file: free-running fixed-point seconds clock
`timescale 1ns/1ps
`default_nettype none
module crf_ts_clock #(
  parameter int RES_BITS = 24,
  parameter logic [31:0] FRAC_STEP = 32'h000001ad
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [63:0] load_value,
  output logic [63:0] ts
);
  logic [63:0] acc_reg;
  logic [63:0] acc_next;
  logic [63:0] mask;
  // mask off fraction bits below resolution
  always_comb begin
    mask = ~64'h0000000000000000;
    for (int i = 0; i < 32 - RES_BITS; i++) begin
      mask[i] = 1'b0;
    end
  end
  // next time: load or advance one clock period
  always_comb begin
    if (load) begin
      acc_next = load_value;
    end else begin
      acc_next = acc_reg + {32'h00000000, FRAC_STEP};
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 64'h0000000000000000;
    end else begin
      acc_reg <= acc_next;
    end
  end
  assign ts = acc_reg & mask;
endmodule : crf_ts_clock
`default_nettype wire

// >>> tb/crf_host_sink.sv
// host memory model that accepts record bytes, stalling when asked
`timescale 1ns/1ps
`default_nettype none
module crf_host_sink (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire crf_pkg::crf_beat_t rec_beat,
  input wire logic rec_valid,
  output logic rec_ready
);
  crf_pkg::crf_beat_t got[$];
  integer sseed = 32'hf00d;
  // ****************
  // beat acceptance
  // ****************
  // store each taken beat; stall at random in slow mode
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rec_ready <= 1'b0;
    end else begin
      if (rec_valid && rec_ready) begin
        got.push_back(rec_beat); // offset byte kept raw, never interpreted
      end
      rec_ready <= !slow || (($random(sseed) & 3) == 0);
    end
  end
endmodule : crf_host_sink
`default_nettype wire

// >>> tb/crf_capture_record_framer_test.sv
// self-checking testbench for the capture record framer
`timescale 1ns/1ps
`default_nettype none
module crf_capture_record_framer_test;
  localparam int MAXB = 24;
  localparam int RES = 24;
  localparam logic [63:0] ZM = (64'h1 << (32 - RES)) - 64'h1;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ts_load = 1'b0;
  logic [63:0] ts_load_value = 64'h0;
  logic varlen_mode = 1'b0;
  logic [15:0] snap_len = 16'h0;
  logic pkt_start = 1'b0;
  crf_pkg::crf_start_t pkt_info = '0;
  logic pkt_valid = 1'b0;
  logic [7:0] pkt_data = 8'h00;
  logic pkt_last = 1'b0;
  logic pkt_drop = 1'b0;
  logic slow = 1'b0;
  logic pkt_ready, rec_valid, rec_ready;
  crf_pkg::crf_beat_t rec_beat;
  logic [63:0] ts_now;
  logic [15:0] loss_count;
  integer num_errors = 0;
  integer compares = 0;
  integer seed = 32'hf00d;
  int k, d;
  // ****************
  // clock and instances
  // ****************
  always #50 core_clk = ~core_clk;
  crf_capture_record_framer #(.MAX_BODY(MAXB), .RES_BITS(RES)) u_crf_capture_record_framer (.core_clk, .nrst,
    .ts_load, .ts_load_value, .varlen_mode, .snap_len, .pkt_start, .pkt_info, .pkt_valid, .pkt_data, .pkt_last,
    .pkt_ready, .pkt_drop, .rec_beat, .rec_valid, .rec_ready, .ts_now, .loss_count);
  crf_host_sink u_crf_host_sink (.core_clk, .nrst, .slow, .rec_beat, .rec_valid, .rec_ready);
  // ****************
  // compare and closing tasks
  // ****************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // one packet in, one record out, then every byte except the offset byte compared, the stamp in full only when hold is set
  task automatic run_pkt(input int n, input int snap, input int drops, input logic hold, input logic [15:0] lexp);
    logic [63:0] tsv;
    logic [7:0] e[18];
    logic [7:0] pay[$];
    logic [7:0] b;
    logic vl;
    int keep, i;
    crf_pkg::crf_start_t inf;
    crf_pkg::crf_beat_t g[$];
    tsv = {$random(seed), $random(seed)};
    inf = crf_pkg::crf_start_t'(20'($random(seed)));
    vl = 1'($random(seed));
    keep = (n < snap) ? n : snap;
    keep = (keep < MAXB) ? keep : MAXB;
    @(posedge core_clk);
    ts_load <= 1'b1;
    ts_load_value <= tsv;
    snap_len <= 16'(snap);
    varlen_mode <= vl;
    slow <= 1'($random(seed));
    repeat (drops) begin
      @(posedge core_clk);
      pkt_drop <= 1'b1;
    end
    @(posedge core_clk);
    pkt_drop <= 1'b0;
    ts_load <= hold;
    pkt_start <= 1'b1;
    pkt_info <= inf;
    for (i = 0; i < n; i++) begin
      @(posedge core_clk);
      pkt_start <= 1'b0;
      b = 8'($random(seed));
      pay.push_back(b);
      pkt_valid <= 1'b1;
      pkt_data <= b;
      pkt_last <= (i == n - 1);
    end
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    pkt_last <= 1'b0;
    pkt_start <= 1'b1; // refused while the record goes out
    @(posedge core_clk);
    pkt_start <= 1'b0;
    ts_load <= 1'b0;
    e[8] = crf_pkg::ethernet_record_code;
    e[9] = {2'b00, inf.int_err, inf.rx_err, 1'(n > keep), vl, inf.intf};
    {e[10], e[11]} = 16'(18 + keep);
    {e[12], e[13]} = lexp;
    {e[14], e[15]} = inf.wire_len;
    e[17] = crf_pkg::PAD_VAL;
    for (i = 0; i < 4000 && u_crf_host_sink.got.size() < 18 + keep; i++) begin
      @(posedge core_clk);
    end
    repeat (30) @(posedge core_clk);
    g = u_crf_host_sink.got;
    u_crf_host_sink.got.delete();
    for (i = 0; i < 8; i++) begin
      chk_byte(g[i].data & (hold ? 8'hff : ZM[8*i+:8]), hold ? tsv[8*i+:8] & ~ZM[8*i+:8] : 8'h00, "stamp");
    end
    for (i = 8; i < 18; i++) begin
      if (i != 16) begin
        chk_byte(g[i].data, e[i], "header");
      end
    end
    for (i = 0; i < keep; i++) begin
      chk_byte(g[18 + i].data, pay[i], "body");
    end
    for (i = 0; i < g.size(); i++) begin
      chk_bit(g[i].sor, i == 0, "start mark");
      chk_bit(g[i].eor, i == 17 + keep, "end mark");
    end
    chk_byte(8'(g.size()), 8'(18 + keep), "count");
    @(negedge core_clk);
    chk_byte(loss_count[7:0] | loss_count[15:8], 8'h00, "loss clear");
  endtask : run_pkt
  // ****************
  // main sequence
  // ****************
  // corner packets, random packets, then loss saturation
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    run_pkt(1, 1, 0, 1'b1, 16'h0000);
    run_pkt(MAXB + 6, 16'hffff, 3, 1'b1, 16'h0003);
    run_pkt(10, 10, 1, 1'b0, 16'h0001);
    run_pkt(11, 10, 2, 1'b1, 16'h0002);
    for (k = 0; k < 30; k++) begin
      d = {$random(seed)} % 4;
      run_pkt(1 + {$random(seed)} % 30, 1 + {$random(seed)} % 30, d, 1'($random(seed)), 16'(d));
    end
    @(posedge core_clk);
    pkt_drop <= 1'b1;
    repeat (65540) @(posedge core_clk);
    pkt_drop <= 1'b0;
    @(negedge core_clk);
    chk_byte(loss_count[7:0] & loss_count[15:8], 8'hff, "loss saturate");
    run_pkt(5, 9, 0, 1'b1, 16'hffff);
    conclude();
  end
  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
endmodule : crf_capture_record_framer_test
`default_nettype wire
